// >>> logic/tsp_pkg.sv
// Shared constants of the transceiver serial control port, both ends
package tsp_pkg;

  localparam int          TSP_CLK_PERIOD_NS     = 50;
  localparam int          TSP_BURST_BITS        = 8;
  localparam int          TSP_WORD_BITS         = 16;
  localparam int          TSP_ADDR_BITS         = 6;
  localparam int          TSP_HDR_RW_POS        = 7;
  localparam logic        TSP_RW_READ           = 1'b1;
  localparam int          TSP_MIN_PAYLOAD_BYTES = 2;
  localparam logic [5:0]  TSP_CFG_ADDR          = 6'h09;
  localparam int          TSP_ALT_EN_POS        = 7;
  localparam logic [15:0] TSP_CFG_RESET         = 16'h0000;
  localparam int          TSP_SCLK_PERIOD_MIN_NS = 125;
  localparam int          TSP_SCLK_LOW_MIN_NS    = 50;
  localparam int          TSP_RST_MIN_NS         = 250;

  // Least times round up to whole cycles
  localparam int TSP_SCLK_PERIOD_MIN_CYC =
    (TSP_SCLK_PERIOD_MIN_NS + TSP_CLK_PERIOD_NS - 1) / TSP_CLK_PERIOD_NS;
  localparam int TSP_SCLK_LOW_MIN_CYC =
    (TSP_SCLK_LOW_MIN_NS + TSP_CLK_PERIOD_NS - 1) / TSP_CLK_PERIOD_NS;
  localparam int TSP_RST_MIN_CYC =
    (TSP_RST_MIN_NS + TSP_CLK_PERIOD_NS - 1) / TSP_CLK_PERIOD_NS;
  // Device sees the link through two flops and answers a cycle later,
  // so each clock phase must outlast that round trip
  localparam int TSP_HALF_MIN_CYC  = 4;
  localparam int TSP_HALF_DEF_CYC  = 4;

endpackage : tsp_pkg

// >>> logic/tsp_link_if.sv
// Serial control link between host controller and transceiver port
`timescale 1ns/1ps
interface tsp_link_if;
  logic ce_n;
  logic serial_clock_in;
  logic mosi;
  logic miso;
  logic miso_oe_n;
  logic chip_rst_n;
  logic general_io_one;
  logic general_io_one_oe_n;
  logic general_io_two;
  logic general_io_two_oe_n;

  modport dev (
    input  ce_n, serial_clock_in, mosi, chip_rst_n,
    output miso, miso_oe_n, general_io_one, general_io_one_oe_n,
    output general_io_two, general_io_two_oe_n
  );
  modport host (
    output ce_n, serial_clock_in, mosi, chip_rst_n,
    input  miso, miso_oe_n, general_io_one, general_io_one_oe_n,
    input  general_io_two, general_io_two_oe_n
  );
endinterface : tsp_link_if

// >>> logic/tsp_device.sv
// Transceiver end of the serial control port: framing, header, payload
`timescale 1ns/1ps
module tsp_device
  import tsp_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        sys_rst,
  tsp_link_if.dev          link,
  input  wire logic        xtal_running,
  input  wire logic        out_of_idle,
  input  wire logic        crc_valid,
  output logic             wr_valid,
  output logic [5:0]       wr_addr,
  output logic [7:0]       wr_index,
  output logic [15:0]      wr_data,
  output logic             rd_req,
  output logic [5:0]       rd_addr,
  output logic [7:0]       rd_index,
  input  wire logic [15:0] rd_data,
  output logic             frame_active,
  output logic             frame_error,
  output logic             alt_enable
);

  typedef enum logic [3:0] {
    TSP_ST_WAIT = 4'b0001,
    TSP_ST_HDR  = 4'b0010,
    TSP_ST_DATA = 4'b0100,
    TSP_ST_SKIP = 4'b1000
  } tsp_dev_state_t;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic [1:0] ce_sync;
  logic [1:0] sclk_sync;
  logic [1:0] mosi_sync;
  logic [1:0] rst_sync;
  logic       sclk_d;
  logic       ce_d;

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      ce_sync   <= 2'h3;
      sclk_sync <= 2'h0;
      mosi_sync <= 2'h0;
      rst_sync  <= 2'h0;
      sclk_d    <= 1'b0;
      ce_d      <= 1'b1;
    end
    else
    begin
      ce_sync   <= {ce_sync[0], link.ce_n};
      sclk_sync <= {sclk_sync[0], link.serial_clock_in};
      mosi_sync <= {mosi_sync[0], link.mosi};
      rst_sync  <= {rst_sync[0], link.chip_rst_n};
      sclk_d    <= sclk_sync[1];
      ce_d      <= ce_sync[1];
    end
  end

  // Chip reset pin acts synchronously: the sampled level clears state
  wire clear      = sys_rst | ~rst_sync[1];
  wire sclk_rise  = sclk_sync[1] & ~sclk_d;
  wire sclk_fall  = ~sclk_sync[1] & sclk_d;
  wire ce_start   = ~ce_sync[1] & ce_d;
  wire ce_end     = ce_sync[1] & ~ce_d;
  wire mosi_s     = mosi_sync[1];

  ////////////////////////////////////////////////////////////////////////////
  // Transaction state

  tsp_dev_state_t state;
  logic [3:0]     bit_cnt;
  logic [15:0]    sh_in;
  logic [15:0]    sh_out;
  logic           hdr_read;
  logic [5:0]     hdr_addr;
  logic [7:0]     word_idx;
  logic [15:0]    cfg;
  logic           miso_q;

  wire st_wait = (state == TSP_ST_WAIT);
  wire st_hdr  = (state == TSP_ST_HDR);
  wire st_data = (state == TSP_ST_DATA);

  wire [15:0] next_sh_in  = {sh_in[14:0], mosi_s};
  wire        hdr_done    = st_hdr & sclk_rise & (bit_cnt == 4'(TSP_BURST_BITS - 1));
  wire        word_done   = st_data & sclk_rise & (bit_cnt == 4'(TSP_WORD_BITS - 1));
  wire        next_read   = next_sh_in[TSP_HDR_RW_POS] == TSP_RW_READ;
  wire [5:0]  next_addr   = next_sh_in[TSP_ADDR_BITS-1:0];
  // Short, odd or headerless frames: header cut short, no whole payload word, or a part word left at the end
  wire        bad_frame   = st_hdr | (st_data & ((bit_cnt != 4'h0) | (word_idx == 8'h00)));
  wire        cfg_hit     = word_done & ~hdr_read & (hdr_addr == TSP_CFG_ADDR) &
                            (word_idx == 8'h00);

  always_ff @(posedge clock)
  begin
    if (clear)
    begin
      state    <= TSP_ST_WAIT;
      bit_cnt  <= 4'h0;
      sh_in    <= 16'h0000;
      sh_out   <= 16'h0000;
      hdr_read <= 1'b0;
      hdr_addr <= 6'h00;
      word_idx <= 8'h00;
      miso_q   <= 1'b0;
    end
    else
    begin
      case (state)
        TSP_ST_WAIT:
        begin
          if (ce_start)
          begin
            // Stopped oscillator: the whole frame is ignored
            state   <= xtal_running ? TSP_ST_HDR : TSP_ST_SKIP;
            bit_cnt <= 4'h0;
            word_idx <= 8'h00;
          end
        end
        TSP_ST_HDR:
        begin
          if (ce_end || !xtal_running)
            state <= ce_end ? TSP_ST_WAIT : TSP_ST_SKIP;
          else if (sclk_rise)
          begin
            sh_in   <= next_sh_in;
            bit_cnt <= hdr_done ? 4'h0 : bit_cnt + 4'h1;
            if (hdr_done)
            begin
              state    <= TSP_ST_DATA;
              hdr_read <= next_read;
              hdr_addr <= next_addr;
            end
          end
        end
        TSP_ST_DATA:
        begin
          if (ce_end || !xtal_running)
          begin
            state  <= ce_end ? TSP_ST_WAIT : TSP_ST_SKIP;
            miso_q <= 1'b0;
          end
          else
          begin
            if (sclk_rise)
            begin
              // Wraps every sixteen bits: payload goes in byte pairs
              sh_in   <= hdr_read ? sh_in : next_sh_in;
              bit_cnt <= bit_cnt + 4'h1;
              if (word_done)
                word_idx <= word_idx + 8'h01;
            end
            if (sclk_fall && hdr_read)
            begin
              miso_q <= (bit_cnt == 4'h0) ? rd_data[15] : sh_out[15];
              sh_out <= (bit_cnt == 4'h0) ? {rd_data[14:0], 1'b0} : {sh_out[14:0], 1'b0};
            end
            else if (!hdr_read)
              miso_q <= 1'b0;
          end
        end
        TSP_ST_SKIP:
        begin
          if (ce_end)
            state <= TSP_ST_WAIT;
        end
        default:
          state <= TSP_ST_WAIT;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Core-side strobes and the alternate-function register

  // Header of a read asks for word 0 at once; each finished word asks for the next
  always_ff @(posedge clock)
  begin
    if (clear)
    begin
      wr_valid    <= 1'b0;
      wr_addr     <= 6'h00;
      wr_index    <= 8'h00;
      wr_data     <= 16'h0000;
      rd_req      <= 1'b0;
      rd_addr     <= 6'h00;
      rd_index    <= 8'h00;
      frame_error <= 1'b0;
      cfg         <= TSP_CFG_RESET;
    end
    else
    begin
      wr_valid    <= word_done & ~hdr_read;
      rd_req      <= (hdr_done & next_read) | (word_done & hdr_read);
      frame_error <= (st_hdr | st_data) & ce_end & bad_frame;
      if (word_done & ~hdr_read)
      begin
        wr_addr  <= hdr_addr;
        wr_index <= word_idx;
        wr_data  <= next_sh_in;
      end
      if (hdr_done)
      begin
        rd_addr  <= next_addr;
        rd_index <= 8'h00;
      end
      else if (word_done)
        rd_index <= word_idx + 8'h01;
      if (cfg_hit)
        cfg <= next_sh_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pins

  logic gio_one;
  logic gio_two;

  always_ff @(posedge clock)
  begin
    if (clear)
    begin
      gio_one <= 1'b0;
      gio_two <= 1'b0;
    end
    else
    begin
      gio_one <= cfg[TSP_ALT_EN_POS] & out_of_idle;
      gio_two <= cfg[TSP_ALT_EN_POS] & crc_valid;
    end
  end

  assign alt_enable                = cfg[TSP_ALT_EN_POS];
  assign frame_active              = st_hdr | st_data;
  // MISO released outside a live frame; low during header and writes
  assign link.miso                 = miso_q;
  assign link.miso_oe_n            = ~(st_hdr | st_data);
  assign link.general_io_one       = gio_one;
  assign link.general_io_one_oe_n  = ~cfg[TSP_ALT_EN_POS];
  assign link.general_io_two       = gio_two;
  assign link.general_io_two_oe_n  = ~cfg[TSP_ALT_EN_POS];

endmodule : tsp_device

// >>> logic/tsp_host.sv
// Host controller end of the serial control port, with read buffer
`timescale 1ns/1ps
module tsp_host
  import tsp_pkg::*;
#(
  parameter int HALF_CYC = TSP_HALF_DEF_CYC
)
(
  input  wire logic        clock,
  input  wire logic        sys_rst,
  tsp_link_if.host         link,
  input  wire logic        cmd_valid,
  output logic             cmd_ready,
  input  wire logic        cmd_read,
  input  wire logic [5:0]  cmd_addr,
  input  wire logic [7:0]  cmd_words,
  input  wire logic        wr_valid,
  output logic             wr_ready,
  input  wire logic [15:0] wr_data,
  output logic             rd_valid,
  input  wire logic        rd_ready,
  output logic [15:0]      rd_data,
  input  wire logic        chip_reset_req,
  output logic             busy,
  output logic             out_of_idle_seen,
  output logic             crc_valid_seen
);

  // Phases shorter than the device's synchroniser round trip lose bits
  if (HALF_CYC < TSP_HALF_MIN_CYC || HALF_CYC > 255 ||
      2 * HALF_CYC < TSP_SCLK_PERIOD_MIN_CYC || HALF_CYC < TSP_SCLK_LOW_MIN_CYC)
  begin : g_bad_half
    $error("tsp_host: HALF_CYC out of range");
  end

  typedef enum logic [5:0] {
    TSP_H_IDLE = 6'b000001,
    TSP_H_LOAD = 6'b000010,
    TSP_H_LOW  = 6'b000100,
    TSP_H_HIGH = 6'b001000,
    TSP_H_END  = 6'b010000,
    TSP_H_GAP  = 6'b100000
  } tsp_host_state_t;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and chip reset stretcher

  logic [1:0] miso_sync;
  logic [1:0] g1_sync;
  logic [1:0] g2_sync;
  logic [2:0] oe_n_s1;
  logic [2:0] oe_n_s2;
  logic [3:0] rst_cnt;

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      miso_sync <= 2'h0;
      g1_sync   <= 2'h0;
      g2_sync   <= 2'h0;
      oe_n_s1   <= 3'h7;
      oe_n_s2   <= 3'h7;
      rst_cnt   <= 4'(TSP_RST_MIN_CYC);
    end
    else
    begin
      miso_sync <= {miso_sync[0], link.miso};
      g1_sync   <= {g1_sync[0], link.general_io_one};
      g2_sync   <= {g2_sync[0], link.general_io_two};
      oe_n_s1   <= {link.miso_oe_n, link.general_io_one_oe_n, link.general_io_two_oe_n};
      oe_n_s2   <= oe_n_s1;
      // Low pulse of at least the least reset width
      if (chip_reset_req)
        rst_cnt <= 4'(TSP_RST_MIN_CYC);
      else if (rst_cnt != 4'h0)
        rst_cnt <= rst_cnt - 4'h1;
    end
  end

  wire chip_in_reset = (rst_cnt != 4'h0);
  // Released pins read as low, judged only after both flops
  wire miso_s        = miso_sync[1] & ~oe_n_s2[2];
  wire g1_s          = g1_sync[1] & ~oe_n_s2[1];
  wire g2_s          = g2_sync[1] & ~oe_n_s2[0];

  ////////////////////////////////////////////////////////////////////////////
  // Transfer engine

  tsp_host_state_t state;
  logic [7:0]      div;
  logic [3:0]      bit_cnt;
  logic [15:0]     sh_out;
  logic [15:0]     sh_in;
  logic            in_hdr;
  logic            is_read;
  logic [7:0]      words_left;
  logic            ce_n_q;
  logic            sclk_q;
  logic [1:0]      cnt;

  wire        div_done  = (div == 8'(HALF_CYC - 1));
  wire [3:0]  last_bit  = in_hdr ? 4'(TSP_BURST_BITS - 1) : 4'(TSP_WORD_BITS - 1);
  wire [15:0] next_sh_in = {sh_in[14:0], miso_s};
  wire        unit_end  = (state == TSP_H_HIGH) & div_done & (bit_cnt == last_bit);
  wire        push      = unit_end & ~in_hdr & is_read;
  wire        space     = (cnt != 2'h2);
  wire        load_ok   = is_read ? space : wr_valid;
  // Zero-word commands would break the least frame length
  assign cmd_ready = (state == TSP_H_IDLE) & ~chip_in_reset & (cmd_words != 8'h00);
  assign wr_ready  = (state == TSP_H_LOAD) & ~is_read;
  assign busy      = (state != TSP_H_IDLE);

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      state      <= TSP_H_IDLE;
      div        <= 8'h00;
      bit_cnt    <= 4'h0;
      sh_out     <= 16'h0000;
      sh_in      <= 16'h0000;
      in_hdr     <= 1'b0;
      is_read    <= 1'b0;
      words_left <= 8'h00;
      ce_n_q     <= 1'b1;
      sclk_q     <= 1'b0;
    end
    else
    begin
      div <= (state == TSP_H_IDLE || state == TSP_H_LOAD || div_done) ? 8'h00 : div + 8'h01;
      case (state)
        TSP_H_IDLE:
        begin
          if (cmd_valid && cmd_ready)
          begin
            ce_n_q     <= 1'b0;
            sh_out     <= {cmd_read, 1'b0, cmd_addr, 8'h00};
            in_hdr     <= 1'b1;
            is_read    <= cmd_read;
            words_left <= cmd_words;
            bit_cnt    <= 4'h0;
            state      <= TSP_H_LOW;
          end
        end
        TSP_H_LOAD:
        begin
          // Clock holds low while data or buffer room is missing
          if (load_ok)
          begin
            sh_out <= is_read ? 16'h0000 : wr_data;
            state  <= TSP_H_LOW;
          end
        end
        TSP_H_LOW:
        begin
          if (div_done)
          begin
            sclk_q <= 1'b1;
            state  <= TSP_H_HIGH;
          end
        end
        TSP_H_HIGH:
        begin
          if (div_done)
          begin
            sclk_q <= 1'b0;
            sh_in  <= next_sh_in;
            if (unit_end)
            begin
              bit_cnt <= 4'h0;
              in_hdr  <= 1'b0;
              if (!in_hdr)
                words_left <= words_left - 8'h01;
              state <= (!in_hdr && words_left == 8'h01) ? TSP_H_END : TSP_H_LOAD;
            end
            else
            begin
              bit_cnt <= bit_cnt + 4'h1;
              sh_out  <= {sh_out[14:0], 1'b0};
              state   <= TSP_H_LOW;
            end
          end
        end
        TSP_H_END:
        begin
          if (div_done)
          begin
            ce_n_q <= 1'b1;
            state  <= TSP_H_GAP;
          end
        end
        TSP_H_GAP:
        begin
          if (div_done)
            state <= TSP_H_IDLE;
        end
        default:
          state <= TSP_H_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Two-entry read buffer; full buffer stalls the serial clock

  logic [15:0] mem [2];
  logic        wp;
  logic        rp;
  wire         pop = rd_valid & rd_ready;

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      wp  <= 1'b0;
      rp  <= 1'b0;
      cnt <= 2'h0;
    end
    else
    begin
      wp  <= wp ^ push;
      rp  <= rp ^ pop;
      cnt <= cnt + {1'b0, push} - {1'b0, pop};
    end
  end

  always_ff @(posedge clock)
  begin
    if (push)
      mem[wp] <= next_sh_in;
  end

  assign rd_valid            = (cnt != 2'h0);
  assign rd_data             = mem[rp];
  assign out_of_idle_seen    = g1_s;
  assign crc_valid_seen      = g2_s;
  assign link.ce_n           = ce_n_q;
  assign link.serial_clock_in = sclk_q;
  assign link.mosi           = sh_out[15];
  assign link.chip_rst_n     = ~chip_in_reset;

endmodule : tsp_host

// >>> dv/tsp_link_monitor.sv
// Wire-level checks on the link between host and device ends
`timescale 1ns/1ps
module tsp_link_monitor (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic ce_n,
  input wire logic serial_clock_in,
  input wire logic miso,
  input wire logic miso_oe_n,
  input wire logic chip_rst_n,
  input wire logic general_io_one_oe_n,
  input wire logic general_io_two_oe_n
);
  logic        sclk_q;
  logic [15:0] rises;

  // Rising clock edges counted per select frame
  always_ff @(posedge clock)
  begin
    sclk_q <= serial_clock_in;
    if (sys_rst || ce_n)
      rises <= 16'h0000;
    else if (serial_clock_in && !sclk_q)
      rises <= rises + 16'h0001;
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);

  ////////////////////////////////////////////////////////////////////////////////
  a_sclk_idle_low: assert property (ce_n |-> !serial_clock_in)
    else $error("serial clock high outside frame");
  a_ce_lead_time: assert property (
    $fell(ce_n) |-> !serial_clock_in [*4] ##1 serial_clock_in)
    else $error("first rise not four cycles after select");
  a_sclk_high_width: assert property (
    $rose(serial_clock_in) |-> serial_clock_in [*4] ##1 !serial_clock_in)
    else $error("clock high phase not four cycles");
  a_ce_trail_time: assert property (
    $rose(ce_n) |-> !$past(serial_clock_in, 1) && !$past(serial_clock_in, 4))
    else $error("select released too soon after last fall");
  a_frame_bit_count: assert property (
    $rose(ce_n) |-> rises >= 16'h0018 && rises[3:0] == 4'h8)
    else $error("frame bit count not header plus whole words");
  a_miso_quiet_high: assert property (
    serial_clock_in && $past(serial_clock_in) |-> $stable(miso))
    else $error("device data moved while clock high");
  a_miso_release: assert property ($rose(ce_n) |-> ##[1:4] miso_oe_n)
    else $error("device data line not released after frame");
  a_chip_rst_width: assert property ($fell(chip_rst_n) |-> !chip_rst_n [*5])
    else $error("chip reset pulse too short");
  a_chip_rst_clears: assert property (
    $fell(chip_rst_n) |-> ##[1:4] (miso_oe_n && general_io_one_oe_n && general_io_two_oe_n))
    else $error("outputs still driven in chip reset");
  a_alt_pins_pair: assert property (
    (general_io_one_oe_n == general_io_two_oe_n) && (!$fell(general_io_one_oe_n) || !ce_n))
    else $error("indicator pins enabled apart or outside a frame");

endmodule : tsp_link_monitor

// >>> dv/test_transceiver_spi_slave_port.sv
// Bench joining host and device ends, plus a raw-driven second device
`timescale 1ns/1ps
module test_transceiver_spi_slave_port
  import tsp_pkg::*;
;
  logic        clock, sys_rst = 1'b1, cmd_valid = 1'b0, cmd_read = 1'b0, wr_valid = 1'b0;
  logic        rd_ready = 1'b0, chip_reset_req = 1'b0, xtal_running = 1'b1;
  logic        out_of_idle = 1'b0, crc_valid = 1'b0, cmd_ready, wr_ready, rd_valid, busy;
  logic        oi_seen, crc_seen, dwv, rd_req, frame_error, alt_enable, fe_b, wv_b, sclk_q, fa;
  logic [5:0]  cmd_addr = 6'h00, dwa, rd_addr, wa_b;
  logic [7:0]  cmd_words = 8'h00, dwi, rd_index, hdr;
  logic [15:0] wr_data = 16'h0000, rd_data, dwd, dev_rd_data = 16'h0000, wd_b;
  logic [31:0] rx;
  logic [29:0] wlog [$];
  int          i, nbit = 0, n_fail = 0, total_checks = 0, cycles = 0;
  int          fe_cnt = 0, wv_cnt = 0, fe_main = 0;

  tsp_link_if link ();
  tsp_link_if link_b ();

  tsp_host tsp_host_inst (.clock, .sys_rst, .link(link), .cmd_valid, .cmd_ready, .cmd_read,
    .cmd_addr, .cmd_words, .wr_valid, .wr_ready, .wr_data, .rd_valid, .rd_ready, .rd_data,
    .chip_reset_req, .busy, .out_of_idle_seen(oi_seen), .crc_valid_seen(crc_seen));
  tsp_device tsp_device_inst (.clock, .sys_rst, .link(link), .xtal_running, .out_of_idle,
    .crc_valid, .wr_valid(dwv), .wr_addr(dwa), .wr_index(dwi), .wr_data(dwd), .rd_req,
    .rd_addr, .rd_index, .rd_data(dev_rd_data), .frame_active(fa), .frame_error, .alt_enable);
  // Second device faces the bench alone, so frames can break the framing rules
  tsp_device tsp_device_inst_b (.clock, .sys_rst, .link(link_b), .xtal_running, .out_of_idle,
    .crc_valid, .wr_valid(wv_b), .wr_addr(wa_b), .wr_index(), .wr_data(wd_b), .rd_req(),
    .rd_addr(), .rd_index(), .rd_data(16'hc3a5), .frame_active(), .frame_error(fe_b),
    .alt_enable());
  tsp_link_monitor tsp_link_monitor_inst (.clock, .sys_rst, .ce_n(link.ce_n),
    .serial_clock_in(link.serial_clock_in), .miso(link.miso), .miso_oe_n(link.miso_oe_n),
    .chip_rst_n(link.chip_rst_n), .general_io_one_oe_n(link.general_io_one_oe_n),
    .general_io_two_oe_n(link.general_io_two_oe_n));

  initial
  begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Watchers: header bits on the wire, device strobes, read-data source
  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    sclk_q <= link.serial_clock_in;
    fe_cnt <= fe_cnt + int'(fe_b);
    wv_cnt <= wv_cnt + int'(wv_b);
    fe_main <= fe_main + int'(frame_error);
    if (dwv)
      wlog.push_back({dwa, dwi, dwd});
    if (rd_req)
      dev_rd_data <= {2'b10, rd_addr, rd_index};
    if (link.ce_n)
      nbit <= 0;
    else if (link.serial_clock_in && !sclk_q)
    begin
      if (nbit < 8)
        hdr <= {hdr[6:0], link.mosi};
      nbit <= nbit + 1;
    end
  end

  always @(posedge clock)
    if (cycles == 30000)
    begin
      n_fail++;
      give_verdict();
    end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check_word(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check_word

  task automatic check_bit(input logic got, input logic exp);
    total_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check_bit

  // Sampled at the falling edge so comb handshakes have settled
  task automatic wait_val(ref logic sig, input logic v);
    int n;
    n = 0;
    do
    begin
      @(negedge clock);
      n++;
    end
    while (sig !== v && n < 4000);
    check_bit(sig, v);
  endtask : wait_val

  task automatic send_cmd(input logic rd, input logic [5:0] a, input logic [7:0] n);
    cmd_valid <= 1'b1;
    cmd_read  <= rd;
    cmd_addr  <= a;
    cmd_words <= n;
    wait_val(cmd_ready, 1'b1);
    @(posedge clock);
    cmd_valid <= 1'b0;
  endtask : send_cmd

  task automatic end_txn(input logic rd, input logic [5:0] a);
    wait_val(busy, 1'b0);
    repeat (8) @(posedge clock);
    check_word({8'h00, hdr}, {8'h00, rd, 1'b0, a});
  endtask : end_txn

  task automatic host_write(input logic [5:0] a, input logic [15:0] d, input int n);
    int k;
    send_cmd(1'b0, a, 8'(n));
    wr_valid <= 1'b1;
    for (k = 0; k < n; k++)
    begin
      wr_data <= d + 16'(k);
      wait_val(wr_ready, 1'b1);
      @(posedge clock);
    end
    wr_valid <= 1'b0;
    end_txn(1'b0, a);
  endtask : host_write

  task automatic pop_n(input logic [5:0] a, input int n);
    int k;
    rd_ready <= 1'b1;
    for (k = 0; k < n; k++)
    begin
      wait_val(rd_valid, 1'b1);
      check_word(rd_data, {2'b10, a, 8'(k)});
      @(posedge clock);
    end
    rd_ready <= 1'b0;
  endtask : pop_n

  task automatic chk_wr(input logic [5:0] a, input logic [7:0] x, input logic [15:0] d);
    logic [29:0] e;
    e = (wlog.size() > 0) ? wlog.pop_front() : 30'h0000_0000;
    check_word({2'b00, e[29:16]}, {2'b00, a, x});
    check_word(e[15:0], d);
  endtask : chk_wr

  // Bench plays host on the second link; mode 0, four cycles per phase
  task automatic raw_case(input logic [31:0] p, input int nb, input logic [15:0] fe,
                          input logic [15:0] wv);
    int k, f0, w0;
    f0 = fe_cnt;
    w0 = wv_cnt;
    link_b.ce_n <= 1'b0;
    for (k = 0; k < nb; k++)
    begin
      link_b.mosi <= p[31 - k];
      repeat (4) @(posedge clock);
      rx = {rx[30:0], link_b.miso};
      link_b.serial_clock_in <= 1'b1;
      repeat (4) @(posedge clock);
      link_b.serial_clock_in <= 1'b0;
    end
    repeat (4) @(posedge clock);
    link_b.ce_n <= 1'b1;
    repeat (16) @(posedge clock);
    check_word(16'(fe_cnt - f0), fe);
    check_word(16'(wv_cnt - w0), wv);
  endtask : raw_case

  task automatic give_verdict();
    $display("checks=%0d fails=%0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : give_verdict

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    link_b.ce_n = 1'b1;
    link_b.serial_clock_in = 1'b0;
    link_b.mosi = 1'b0;
    link_b.chip_rst_n = 1'b1;
    repeat (8) @(posedge clock);
    sys_rst <= 1'b0;
    repeat (12) @(posedge clock);
    host_write(TSP_CFG_ADDR, 16'h0080, 1);
    chk_wr(TSP_CFG_ADDR, 8'h00, 16'h0080);
    check_bit(alt_enable, 1'b1);
    out_of_idle <= 1'b1;
    repeat (8) @(posedge clock);
    check_bit(oi_seen, 1'b1);
    check_bit(crc_seen, 1'b0);
    out_of_idle <= 1'b0;
    crc_valid <= 1'b1;
    repeat (8) @(posedge clock);
    check_bit(oi_seen, 1'b0);
    check_bit(crc_seen, 1'b1);
    // Longer payload wraps the data value; read follows at once
    host_write(6'h2a, 16'hfffe, 3);
    for (i = 0; i < 3; i++)
      chk_wr(6'h2a, 8'(i), 16'hfffe + 16'(i));
    send_cmd(1'b1, 6'h3f, 8'h01);
    pop_n(6'h3f, 1);
    end_txn(1'b1, 6'h3f);
    // Reader stalls: two words parked, the link must wait for room
    send_cmd(1'b1, 6'h12, 8'h04);
    repeat (1500) @(posedge clock);
    check_bit(busy, 1'b1);
    check_bit(rd_valid, 1'b1);
    check_bit(fa, 1'b1);
    pop_n(6'h12, 4);
    end_txn(1'b1, 6'h12);
    check_bit(fa, 1'b0);
    check_bit(rd_valid, 1'b0);
    xtal_running <= 1'b0;
    host_write(6'h03, 16'h1357, 1);
    check_word(16'(wlog.size()), 16'h0000);
    xtal_running <= 1'b1;
    chip_reset_req <= 1'b1;
    repeat (10) @(posedge clock);
    chip_reset_req <= 1'b0;
    repeat (20) @(posedge clock);
    check_bit(alt_enable, 1'b0);
    check_bit(link.general_io_one_oe_n, 1'b1);
    host_write(6'h01, 16'h8001, 1);
    chk_wr(6'h01, 8'h00, 16'h8001);
    raw_case(32'h0500_0000, 8, 16'h0001, 16'h0000);
    raw_case(32'h05a5_5a00, 24, 16'h0000, 16'h0001);
    check_word(wd_b, 16'ha55a);
    check_word({10'h000, wa_b}, 16'h0005);
    raw_case(32'h0511_1122, 32, 16'h0001, 16'h0001);
    raw_case(32'h85ff_ff00, 24, 16'h0000, 16'h0000);
    check_word(rx[15:0], 16'hc3a5);
    check_word(16'(fe_main), 16'h0000);
    give_verdict();
  end

endmodule : test_transceiver_spi_slave_port
